// ==== shared/cbt_pkg.sv ====
package cbt_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	// status flag bit positions inside the flag register
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	// register map
	localparam logic [11:0] OFS_OP = 12'h000;
	localparam logic [11:0] OFS_IMM = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_PC = 12'h00c;
	localparam logic [11:0] OFS_SP = 12'h010;
	localparam logic [11:0] OFS_DM_ADDR = 12'h014;
	localparam logic [11:0] OFS_DM_DATA = 12'h018;
	localparam logic [11:0] OFS_FLAGS = 12'h01c;
	localparam logic [11:0] OFS_IO_ADDR = 12'h020;
	localparam logic [11:0] OFS_IO_DATA = 12'h024;
	localparam logic [11:0] REG_WIN_BASE = 12'h100;
	localparam logic [11:0] REG_WIN_MASK = 12'hf80;
	// fields of the instruction word
	localparam int OP_LSB = 0;
	localparam int RD_LSB = 8;
	localparam int RR_LSB = 16;
	localparam int SEL_LSB = 24;
	localparam int MODE_LSB = 28;
	localparam int STAT_BUSY = 0;
	localparam int STAT_FLAGS_LSB = 8;
	// pointer pairs: low register index of each
	localparam logic [4:0] PTR_X_LO = 5'h1a;
	localparam logic [4:0] PTR_Y_LO = 5'h1c;
	localparam logic [4:0] PTR_Z_LO = 5'h1e;
	localparam logic [4:0] REG_R0 = 5'h00;
	localparam logic [1:0] SEL_X = 2'h0;
	localparam logic [1:0] SEL_Y = 2'h1;
	localparam logic [1:0] MODE_PLAIN = 2'h0;
	localparam logic [1:0] MODE_POSTINC = 2'h1;
	localparam logic [1:0] MODE_PREDEC = 2'h2;
	// cycle counts
	localparam logic [7:0] CYC_1 = 8'h01;
	localparam logic [7:0] CYC_2 = 8'h02;
	localparam logic [7:0] CYC_3 = 8'h03;
	localparam logic [15:0] PC_STEP_1 = 16'h0001;
	localparam logic [15:0] PC_STEP_2 = 16'h0002;
	localparam logic [15:0] SP_RESET = 16'h03ff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [5:0] {
		OP_NOP,
		OP_BRANCH_IF_OVERFLOW_CLEAR,
		OP_BRANCH_IF_IRQ_ON,
		OP_BRANCH_IF_IRQ_OFF,
		OP_IO_BIT_RAISE,
		OP_IO_BIT_DROP,
		OP_SHIFT_LEFT_LOGICAL,
		OP_SHIFT_RIGHT_LOGICAL,
		OP_CARRY_ROTATE_LEFT,
		OP_CARRY_ROTATE_RIGHT,
		OP_SHIFT_RIGHT_SIGNED,
		OP_FLAG_BY_INDEX_ON,
		OP_FLAG_BY_INDEX_OFF,
		OP_BIT_TO_TRANSFER_FLAG,
		OP_TRANSFER_FLAG_TO_BIT,
		OP_IRQ_GLOBAL_ON,
		OP_IRQ_GLOBAL_OFF,
		OP_REG_COPY,
		OP_REG_PAIR_COPY,
		OP_IMMEDIATE_LOAD,
		OP_INDIRECT_READ,
		OP_DISPLACED_READ,
		OP_DIRECT_READ,
		OP_INDIRECT_WRITE,
		OP_DISPLACED_WRITE,
		OP_DIRECT_WRITE,
		OP_PROGRAM_MEM_READ,
		OP_PROGRAM_MEM_WRITE,
		OP_STACK_PUSH,
		OP_PORT_IN,
		OP_PORT_OUT
	} cbt_op_t;

	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] sel;
		logic [4:0] rr;
		logic [4:0] rd;
		cbt_op_t op;
	} cbt_instr_t;
endpackage : cbt_pkg

// ==== verilog/cbt_exec_unit.sv ====
`timescale 1ns/1ps
module cbt_exec_unit #(
	parameter int DMEM_AW = 10,
	parameter int IO_AW = 6,
	parameter int PMEM_AW = 13,
	parameter logic [7:0] SPM_CYCLES = 8'h04
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic busy
);
	logic [7:0] rf [32];
	logic [7:0] dmem [2**DMEM_AW];
	logic [7:0] iomem [2**IO_AW];
	logic [15:0] pmem [2**PMEM_AW];

	logic [31:0] op_word_q;
	logic [15:0] imm_q;
	logic [15:0] pc_q;
	logic [15:0] sp_q;
	logic [7:0] flags_q;
	logic [15:0] dm_addr_q;
	logic [IO_AW-1:0] io_addr_q;
	logic ex_q;
	logic [7:0] wait_q;

	logic aw_full_q;
	logic w_full_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// ---------------- bus slave ----------------
	logic wr_fire;
	logic [31:0] wr_val;
	logic wr_mapped;
	logic wr_ok;
	logic in_win_w;
	logic [4:0] win_idx_w;

	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign busy = ex_q || (wait_q != 8'h00);

	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
	assign in_win_w = (awaddr_q & cbt_pkg::REG_WIN_MASK) == cbt_pkg::REG_WIN_BASE;
	assign win_idx_w = awaddr_q[6:2];
	assign wr_val = wdata_q;
	always_comb begin
		case (awaddr_q)
			cbt_pkg::OFS_OP, cbt_pkg::OFS_IMM, cbt_pkg::OFS_PC, cbt_pkg::OFS_SP,
			cbt_pkg::OFS_DM_ADDR, cbt_pkg::OFS_DM_DATA, cbt_pkg::OFS_FLAGS,
			cbt_pkg::OFS_IO_ADDR, cbt_pkg::OFS_IO_DATA: wr_mapped = 1'b1;
			default: wr_mapped = in_win_w;
		endcase
	end
	// state writes while an instruction runs would race it, so they are refused
	assign wr_ok = wr_fire && wr_mapped && !busy;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= cbt_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= !wr_mapped ? cbt_pkg::RESP_DECERR :
					(busy ? cbt_pkg::RESP_SLVERR : cbt_pkg::RESP_OKAY);
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	logic [31:0] rd_mux;
	logic rd_mapped;
	always_comb begin
		rd_mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
			cbt_pkg::OFS_OP: rd_mux = op_word_q;
			cbt_pkg::OFS_IMM: rd_mux = {16'h0000, imm_q};
			cbt_pkg::OFS_STATUS: begin
				rd_mux[cbt_pkg::STAT_BUSY] = busy;
				rd_mux[cbt_pkg::STAT_FLAGS_LSB +: 8] = flags_q;
			end
			cbt_pkg::OFS_PC: rd_mux = {16'h0000, pc_q};
			cbt_pkg::OFS_SP: rd_mux = {16'h0000, sp_q};
			cbt_pkg::OFS_DM_ADDR: rd_mux = {16'h0000, dm_addr_q};
			cbt_pkg::OFS_DM_DATA: rd_mux = {24'h00_0000, dmem[dm_addr_q[DMEM_AW-1:0]]};
			cbt_pkg::OFS_FLAGS: rd_mux = {24'h00_0000, flags_q};
			cbt_pkg::OFS_IO_ADDR: rd_mux[IO_AW-1:0] = io_addr_q;
			cbt_pkg::OFS_IO_DATA: rd_mux = {24'h00_0000, iomem[io_addr_q]};
			default: begin
				rd_mapped = (s_axi_araddr & cbt_pkg::REG_WIN_MASK) == cbt_pkg::REG_WIN_BASE;
				if (rd_mapped) begin
					rd_mux = {24'h00_0000, rf[s_axi_araddr[6:2]]};
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= cbt_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_mapped ? cbt_pkg::RESP_OKAY : cbt_pkg::RESP_DECERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ---------------- instruction issue ----------------
	cbt_pkg::cbt_instr_t ins;
	assign ins.op = cbt_pkg::cbt_op_t'(op_word_q[cbt_pkg::OP_LSB +: 6]);
	assign ins.rd = op_word_q[cbt_pkg::RD_LSB +: 5];
	assign ins.rr = op_word_q[cbt_pkg::RR_LSB +: 5];
	assign ins.sel = op_word_q[cbt_pkg::SEL_LSB +: 3];
	assign ins.mode = op_word_q[cbt_pkg::MODE_LSB +: 2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_word_q <= 32'h0000_0000;
			imm_q <= 16'h0000;
			dm_addr_q <= 16'h0000;
			io_addr_q <= '0;
			ex_q <= 1'b0;
		end else begin
			ex_q <= wr_ok && (awaddr_q == cbt_pkg::OFS_OP);
			if (wr_ok && awaddr_q == cbt_pkg::OFS_OP) begin
				op_word_q <= merge(op_word_q, wr_val, wstrb_q);
			end
			if (wr_ok && awaddr_q == cbt_pkg::OFS_IMM) begin
				imm_q <= 16'(merge({16'h0000, imm_q}, wr_val, wstrb_q));
			end
			if (wr_ok && awaddr_q == cbt_pkg::OFS_DM_ADDR) begin
				dm_addr_q <= 16'(merge({16'h0000, dm_addr_q}, wr_val, wstrb_q));
			end
			if (wr_ok && awaddr_q == cbt_pkg::OFS_IO_ADDR) begin
				io_addr_q <= wr_val[IO_AW-1:0];
			end
		end
	end

	// ---------------- execute ----------------
	logic [7:0] vd;
	logic [7:0] vr;
	logic [4:0] ptr_lo;
	logic [15:0] ptr;
	logic [15:0] ptr_step;
	logic [15:0] eff;
	logic [15:0] zptr;
	logic [7:0] sh_res;
	logic sh_c;
	logic taken;
	logic [15:0] br_ofs;
	logic [7:0] cyc;

	assign vd = rf[ins.rd];
	assign vr = rf[ins.rr];
	assign zptr = {rf[cbt_pkg::PTR_Z_LO + 5'h01], rf[cbt_pkg::PTR_Z_LO]};
	always_comb begin
		case (ins.sel[1:0])
			cbt_pkg::SEL_X: ptr_lo = cbt_pkg::PTR_X_LO;
			cbt_pkg::SEL_Y: ptr_lo = cbt_pkg::PTR_Y_LO;
			default: ptr_lo = cbt_pkg::PTR_Z_LO;
		endcase
	end
	assign ptr = {rf[ptr_lo + 5'h01], rf[ptr_lo]};
	assign ptr_step = (ins.mode == cbt_pkg::MODE_PREDEC) ? ptr - 16'h0001 : ptr + 16'h0001;
	always_comb begin
		case (ins.op)
			cbt_pkg::OP_INDIRECT_READ, cbt_pkg::OP_INDIRECT_WRITE:
				eff = (ins.mode == cbt_pkg::MODE_PREDEC) ? ptr_step : ptr;
			cbt_pkg::OP_DISPLACED_READ, cbt_pkg::OP_DISPLACED_WRITE: eff = ptr + imm_q;
			default: eff = imm_q;
		endcase
	end

	always_comb begin
		case (ins.op)
			cbt_pkg::OP_SHIFT_LEFT_LOGICAL: {sh_c, sh_res} = {vd, 1'b0};
			cbt_pkg::OP_CARRY_ROTATE_LEFT: {sh_c, sh_res} = {vd, flags_q[cbt_pkg::FLAG_C]};
			cbt_pkg::OP_SHIFT_RIGHT_LOGICAL: {sh_res, sh_c} = {1'b0, vd};
			cbt_pkg::OP_CARRY_ROTATE_RIGHT: {sh_res, sh_c} = {flags_q[cbt_pkg::FLAG_C], vd};
			cbt_pkg::OP_SHIFT_RIGHT_SIGNED: {sh_res, sh_c} = {vd[7], vd};
			default: {sh_c, sh_res} = 9'h000;
		endcase
	end

	always_comb begin
		case (ins.op)
			cbt_pkg::OP_BRANCH_IF_OVERFLOW_CLEAR: taken = !flags_q[cbt_pkg::FLAG_V];
			cbt_pkg::OP_BRANCH_IF_IRQ_ON: taken = flags_q[cbt_pkg::FLAG_I];
			cbt_pkg::OP_BRANCH_IF_IRQ_OFF: taken = !flags_q[cbt_pkg::FLAG_I];
			default: taken = 1'b0;
		endcase
	end
	// 7-bit signed offset, as the short branch form carries
	assign br_ofs = {{9{imm_q[6]}}, imm_q[6:0]};

	always_comb begin
		case (ins.op)
			cbt_pkg::OP_BRANCH_IF_OVERFLOW_CLEAR, cbt_pkg::OP_BRANCH_IF_IRQ_ON,
			cbt_pkg::OP_BRANCH_IF_IRQ_OFF: cyc = taken ? cbt_pkg::CYC_2 : cbt_pkg::CYC_1;
			cbt_pkg::OP_IO_BIT_RAISE, cbt_pkg::OP_IO_BIT_DROP,
			cbt_pkg::OP_INDIRECT_READ, cbt_pkg::OP_DISPLACED_READ, cbt_pkg::OP_DIRECT_READ,
			cbt_pkg::OP_INDIRECT_WRITE, cbt_pkg::OP_DISPLACED_WRITE,
			cbt_pkg::OP_DIRECT_WRITE, cbt_pkg::OP_STACK_PUSH: cyc = cbt_pkg::CYC_2;
			cbt_pkg::OP_PROGRAM_MEM_READ: cyc = cbt_pkg::CYC_3;
			cbt_pkg::OP_PROGRAM_MEM_WRITE: cyc = SPM_CYCLES;
			default: cyc = cbt_pkg::CYC_1;
		endcase
	end

	// busy counter covers the cycles after the one that does the work
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_q <= 8'h00;
		end else if (ex_q) begin
			wait_q <= cyc - cbt_pkg::CYC_1;
		end else if (wait_q != 8'h00) begin
			wait_q <= wait_q - 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_q <= 16'h0000;
		end else if (ex_q) begin
			// taken branch adds offset plus one
			if (taken) begin
				pc_q <= pc_q + br_ofs + cbt_pkg::PC_STEP_1;
			end else if (ins.op == cbt_pkg::OP_DIRECT_READ ||
					ins.op == cbt_pkg::OP_DIRECT_WRITE) begin
				pc_q <= pc_q + cbt_pkg::PC_STEP_2;
			end else begin
				pc_q <= pc_q + cbt_pkg::PC_STEP_1;
			end
		end else if (wr_ok && awaddr_q == cbt_pkg::OFS_PC) begin
			pc_q <= 16'(merge({16'h0000, pc_q}, wr_val, wstrb_q));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sp_q <= cbt_pkg::SP_RESET;
		end else if (ex_q && ins.op == cbt_pkg::OP_STACK_PUSH) begin
			sp_q <= sp_q - 16'h0001;
		end else if (wr_ok && awaddr_q == cbt_pkg::OFS_SP) begin
			sp_q <= 16'(merge({16'h0000, sp_q}, wr_val, wstrb_q));
		end
	end

	// flag register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= 8'h00;
		end else if (ex_q) begin
			case (ins.op)
				cbt_pkg::OP_SHIFT_LEFT_LOGICAL, cbt_pkg::OP_SHIFT_RIGHT_LOGICAL,
				cbt_pkg::OP_CARRY_ROTATE_LEFT, cbt_pkg::OP_CARRY_ROTATE_RIGHT,
				cbt_pkg::OP_SHIFT_RIGHT_SIGNED: begin
					flags_q[cbt_pkg::FLAG_Z] <= sh_res == 8'h00;
					flags_q[cbt_pkg::FLAG_C] <= sh_c;
					flags_q[cbt_pkg::FLAG_N] <= sh_res[7];
					flags_q[cbt_pkg::FLAG_V] <= sh_res[7] ^ sh_c;
				end
				cbt_pkg::OP_FLAG_BY_INDEX_ON: flags_q[ins.sel] <= 1'b1;
				cbt_pkg::OP_FLAG_BY_INDEX_OFF: flags_q[ins.sel] <= 1'b0;
				cbt_pkg::OP_BIT_TO_TRANSFER_FLAG: flags_q[cbt_pkg::FLAG_T] <= vr[ins.sel];
				cbt_pkg::OP_IRQ_GLOBAL_ON: flags_q[cbt_pkg::FLAG_I] <= 1'b1;
				cbt_pkg::OP_IRQ_GLOBAL_OFF: flags_q[cbt_pkg::FLAG_I] <= 1'b0;
				default: flags_q <= flags_q;
			endcase
		end else if (wr_ok && awaddr_q == cbt_pkg::OFS_FLAGS && wstrb_q[0]) begin
			flags_q <= wr_val[7:0];
		end
	end

	// register file: one byte port and one pointer/pair port
	logic [15:0] pm_word;
	logic [7:0] pm_byte;
	assign pm_word = pmem[zptr[PMEM_AW:1]];
	assign pm_byte = zptr[0] ? pm_word[15:8] : pm_word[7:0];

	always_ff @(posedge aclk) begin
		if (ex_q) begin
			case (ins.op)
				cbt_pkg::OP_SHIFT_LEFT_LOGICAL, cbt_pkg::OP_SHIFT_RIGHT_LOGICAL,
				cbt_pkg::OP_CARRY_ROTATE_LEFT, cbt_pkg::OP_CARRY_ROTATE_RIGHT,
				cbt_pkg::OP_SHIFT_RIGHT_SIGNED: rf[ins.rd] <= sh_res;
				cbt_pkg::OP_TRANSFER_FLAG_TO_BIT: rf[ins.rd][ins.sel] <= flags_q[cbt_pkg::FLAG_T];
				cbt_pkg::OP_REG_COPY: rf[ins.rd] <= vr;
				cbt_pkg::OP_REG_PAIR_COPY: begin
					rf[{ins.rd[4:1], 1'b0}] <= rf[{ins.rr[4:1], 1'b0}];
					rf[{ins.rd[4:1], 1'b1}] <= rf[{ins.rr[4:1], 1'b1}];
				end
				cbt_pkg::OP_IMMEDIATE_LOAD: rf[ins.rd] <= imm_q[7:0];
				cbt_pkg::OP_DISPLACED_READ, cbt_pkg::OP_DIRECT_READ:
					rf[ins.rd] <= dmem[eff[DMEM_AW-1:0]];
				cbt_pkg::OP_INDIRECT_READ: begin
					if (ins.mode != cbt_pkg::MODE_PLAIN) begin
						rf[ptr_lo] <= ptr_step[7:0];
						rf[ptr_lo + 5'h01] <= ptr_step[15:8];
					end
					// loaded byte wins if the target is the pointer itself
					rf[ins.rd] <= dmem[eff[DMEM_AW-1:0]];
				end
				cbt_pkg::OP_INDIRECT_WRITE: begin
					if (ins.mode != cbt_pkg::MODE_PLAIN) begin
						rf[ptr_lo] <= ptr_step[7:0];
						rf[ptr_lo + 5'h01] <= ptr_step[15:8];
					end
				end
				// byte from program memory via Z
				cbt_pkg::OP_PROGRAM_MEM_READ: begin
					if (ins.mode == cbt_pkg::MODE_POSTINC) begin
						rf[cbt_pkg::PTR_Z_LO] <= zptr[7:0] + 8'h01;
						rf[cbt_pkg::PTR_Z_LO + 5'h01] <= zptr[15:8] + {7'h00, &zptr[7:0]};
					end
					rf[(ins.mode == cbt_pkg::MODE_PLAIN) ? cbt_pkg::REG_R0 : ins.rd] <= pm_byte;
				end
				cbt_pkg::OP_PORT_IN: rf[ins.rd] <= iomem[imm_q[IO_AW-1:0]];
				default: ;
			endcase
		end else if (wr_ok && in_win_w && wstrb_q[0]) begin
			rf[win_idx_w] <= wr_val[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (ex_q) begin
			case (ins.op)
				cbt_pkg::OP_INDIRECT_WRITE, cbt_pkg::OP_DISPLACED_WRITE,
				cbt_pkg::OP_DIRECT_WRITE: dmem[eff[DMEM_AW-1:0]] <= vr;
				cbt_pkg::OP_STACK_PUSH: dmem[sp_q[DMEM_AW-1:0]] <= vr;
				default: ;
			endcase
		end else if (wr_ok && awaddr_q == cbt_pkg::OFS_DM_DATA && wstrb_q[0]) begin
			dmem[dm_addr_q[DMEM_AW-1:0]] <= wr_val[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (ex_q) begin
			case (ins.op)
				cbt_pkg::OP_IO_BIT_RAISE: iomem[imm_q[IO_AW-1:0]][ins.sel] <= 1'b1;
				cbt_pkg::OP_IO_BIT_DROP: iomem[imm_q[IO_AW-1:0]][ins.sel] <= 1'b0;
				cbt_pkg::OP_PORT_OUT: iomem[imm_q[IO_AW-1:0]] <= vr;
				default: ;
			endcase
		end else if (wr_ok && awaddr_q == cbt_pkg::OFS_IO_DATA && wstrb_q[0]) begin
			iomem[io_addr_q] <= wr_val[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (ex_q && ins.op == cbt_pkg::OP_PROGRAM_MEM_WRITE) begin
			pmem[zptr[PMEM_AW:1]] <= {rf[cbt_pkg::REG_R0 + 5'h01], rf[cbt_pkg::REG_R0]};
		end
	end
endmodule : cbt_exec_unit

// ==== bench/cbt_resp_sink.sv ====
`timescale 1ns/1ps
// response side of the master: prompt, or ready only after two valid cycles
module cbt_resp_sink (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic stall,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	output logic s_axi_bready,
	output logic s_axi_rready
);
	logic [1:0] wait_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || !(s_axi_bvalid || s_axi_rvalid)) wait_q <= 2'h0;
		else wait_q <= {wait_q[0], 1'b1};
	end
	// ready never drops before the valid it waits for was taken
	assign s_axi_bready = !stall || wait_q[1];
	assign s_axi_rready = !stall || wait_q[1];
endmodule : cbt_resp_sink

// ==== bench/cbt_exec_chk.sv ====
`timescale 1ns/1ps
module cbt_exec_chk #(
	parameter logic [7:0] SPM_CYCLES = 8'h04
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic busy
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [11:0] aw_q;
	logic [5:0] op_q;
	logic bv_q;
	logic launch;
	int n;
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
	end
	always_ff @(posedge aclk) begin
		if (s_axi_wvalid && s_axi_wready) op_q <= s_axi_wdata[5:0];
	end
	always_ff @(posedge aclk) begin
		bv_q <= aresetn && s_axi_bvalid;
	end
	// an accepted write to the opcode word starts one instruction
	assign launch = s_axi_bvalid && !bv_q && s_axi_bresp == cbt_pkg::RESP_OKAY
		&& aw_q == cbt_pkg::OFS_OP;
	always_comb begin
		case (op_q)
			6'h01, 6'h02, 6'h03: n = 9;
			6'h04, 6'h05, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1c: n = 2;
			6'h1a: n = 3;
			6'h1b: n = int'(SPM_CYCLES);
			default: n = 1;
		endcase
	end
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read response dropped early");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_b_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write answer late");
	property p_decerr;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h040
			|=> s_axi_rresp == cbt_pkg::RESP_DECERR && s_axi_rdata == 32'h0000_0000;
	endproperty
	a_decerr: assert property (p_decerr) else $error("unmapped read not refused");
	property p_one;
		launch && n == 1 |-> busy ##1 !busy;
	endproperty
	a_one: assert property (p_one) else $error("one cycle op length");
	property p_two;
		launch && n == 2 |-> busy [*2] ##1 !busy;
	endproperty
	a_two: assert property (p_two) else $error("two cycle op length");
	property p_three;
		launch && n == 3 |-> busy [*3] ##1 !busy;
	endproperty
	a_three: assert property (p_three) else $error("three cycle op length");
	property p_branch;
		launch && n == 9 |-> busy ##1 (!busy or (busy ##1 !busy));
	endproperty
	a_branch: assert property (p_branch) else $error("branch length");
	c_two: cover property (launch && n == 2);
	c_three: cover property (launch && n == 3);
	c_stall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule : cbt_exec_chk

bind cbt_exec_unit cbt_exec_chk #(.SPM_CYCLES(SPM_CYCLES)) i_chk (.aclk, .aresetn,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .busy);

// ==== bench/cpu_bit_and_transfer_ops_tb.sv ====
`timescale 1ns/1ps
module cpu_bit_and_transfer_ops_tb;
	localparam logic [11:0] A_OP = cbt_pkg::OFS_OP;
	localparam logic [11:0] A_IM = cbt_pkg::OFS_IMM;
	localparam logic [11:0] A_FL = cbt_pkg::OFS_FLAGS;
	localparam logic [11:0] A_DA = cbt_pkg::OFS_DM_ADDR;
	localparam logic [11:0] A_DD = cbt_pkg::OFS_DM_DATA;
	localparam logic [11:0] A_ID = cbt_pkg::OFS_IO_DATA;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic stall = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, busy;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] rv;
	logic [7:0] sh_r [5] = '{8'h4a, 8'h52, 8'h4b, 8'hd2, 8'hd2};
	logic [7:0] sh_f [5] = '{8'h79, 8'h79, 8'h79, 8'h75, 8'h75};
	logic [5:0] br_op [6] = '{6'h01, 6'h01, 6'h02, 6'h02, 6'h03, 6'h03};
	logic [7:0] br_fl [6] = '{8'h00, 8'h08, 8'h80, 8'h00, 8'h00, 8'h80};
	logic [7:0] br_pc [6] = '{8'h0f, 8'h11, 8'h0f, 8'h11, 8'h0f, 8'h11};
	int bad_count = 0;
	int n_tests = 0;
	int i;
	cbt_exec_unit #(.SPM_CYCLES(8'h06)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .busy);
	cbt_resp_sink i_sink (.aclk, .aresetn, .stall, .s_axi_bvalid, .s_axi_rvalid,
		.s_axi_bready, .s_axi_rready);
	initial begin
		forever #2 aclk = ~aclk;
	end
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// handshakes are judged at the falling edge, where nothing moves
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ao, wo, bo;
		int t;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		bo = 1'b0;
		for (t = 0; t < 64 && !bo; t++) begin
			@(negedge aclk);
			ao = s_axi_awvalid && s_axi_awready;
			wo = s_axi_wvalid && s_axi_wready;
			bo = s_axi_bvalid && s_axi_bready;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ao) s_axi_awvalid <= 1'b0;
			if (wo) s_axi_wvalid <= 1'b0;
		end
		if (!bo) bad_count++;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
		logic ao, ro;
		int t;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		ro = 1'b0;
		for (t = 0; t < 64 && !ro; t++) begin
			@(negedge aclk);
			ao = s_axi_arvalid && s_axi_arready;
			ro = s_axi_rvalid && s_axi_rready;
			v = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ao) s_axi_arvalid <= 1'b0;
		end
		if (!ro) bad_count++;
	endtask : rd
	task automatic w(input logic [11:0] a, input logic [31:0] d);
		wr(a, d, rs);
	endtask : w
	task automatic ck(input logic [11:0] a, input logic [31:0] e);
		rd(a, rv, rs);
		chk(rv, e);
	endtask : ck
	task automatic sr(input int n, input logic [7:0] v);
		w(cbt_pkg::REG_WIN_BASE + 12'(n * 4), {24'h0, v});
	endtask : sr
	task automatic ckr(input int n, input logic [7:0] e);
		ck(cbt_pkg::REG_WIN_BASE + 12'(n * 4), {24'h0, e});
	endtask : ckr
	task automatic idle;
		int t;
		for (t = 0; t < 16; t++) begin
			rd(cbt_pkg::OFS_STATUS, rv, rs);
			if (rv[0] === 1'b0) break;
		end
	endtask : idle
	function automatic logic [31:0] f(input logic [5:0] op, input logic [4:0] d,
		input logic [4:0] r, input logic [2:0] s, input logic [1:0] m);
		return {2'h0, m, 1'b0, s, 3'h0, r, 3'h0, d, 2'h0, op};
	endfunction : f
	task automatic ex(input logic [31:0] iw);
		w(A_OP, iw);
		idle();
	endtask : ex
	initial begin
		#100000;
		bad_count++;
		final_report();
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		ck(cbt_pkg::OFS_SP, {16'h0000, cbt_pkg::SP_RESET});
		rd(12'h040, rv, rs);
		chk({30'h0, rs}, {30'h0, cbt_pkg::RESP_DECERR});
		$display("end of reset checks");
		for (i = 0; i < 5; i++) begin
			w(A_FL, 32'h0000_0071);
			sr(5, 8'ha5);
			ex(f(6'(6 + i), 5'h05, 5'h00, 3'h0, 2'h0));
			ckr(5, sh_r[i]);
			ck(A_FL, {24'h0, sh_f[i]});
		end
		for (i = 0; i < 8; i++) begin
			w(A_FL, 32'h0000_0000);
			ex(f(6'h0b, 5'h00, 5'h00, 3'(i), 2'h0));
			ck(A_FL, 32'h1 << i);
			w(A_FL, 32'h0000_00ff);
			ex(f(6'h0c, 5'h00, 5'h00, 3'(i), 2'h0));
			ck(A_FL, 32'h0000_00ff ^ (32'h1 << i));
		end
		ex(f(6'h0f, 5'h00, 5'h00, 3'h0, 2'h0));
		ck(A_FL, 32'h0000_00ff);
		ex(f(6'h10, 5'h00, 5'h00, 3'h0, 2'h0));
		ck(A_FL, 32'h0000_007f);
		$display("end of flag tests");
		w(A_IM, 32'h0000_007e);
		for (i = 0; i < 6; i++) begin
			w(A_FL, {24'h0, br_fl[i]});
			w(cbt_pkg::OFS_PC, 32'h0000_0010);
			ex(f(br_op[i], 5'h00, 5'h00, 3'h0, 2'h0));
			ck(cbt_pkg::OFS_PC, {24'h0, br_pc[i]});
		end
		ex(f(6'h13, 5'h10, 5'h00, 3'h0, 2'h0));
		ckr(16, 8'h7e);
		$display("end of branch tests");
		w(A_FL, 32'h0000_0000);
		sr(3, 8'h10);
		ex(f(6'h0d, 5'h00, 5'h03, 3'h4, 2'h0));
		sr(4, 8'h01);
		ex(f(6'h0e, 5'h04, 5'h00, 3'h7, 2'h0));
		ckr(4, 8'h81);
		sr(7, 8'h5a);
		sr(6, 8'h12);
		ex(f(6'h11, 5'h08, 5'h07, 3'h0, 2'h0));
		ckr(8, 8'h5a);
		ex(f(6'h12, 5'h0a, 5'h06, 3'h0, 2'h0));
		ckr(10, 8'h12);
		ckr(11, 8'h5a);
		ck(A_FL, 32'h0000_0040);
		$display("end of bit and copy tests");
		sr(26, 8'hff);
		sr(27, 8'h00);
		sr(2, 8'h33);
		ex(f(6'h17, 5'h00, 5'h02, 3'h0, cbt_pkg::MODE_POSTINC));
		ckr(27, 8'h01);
		w(A_DA, 32'h0000_00ff);
		ck(A_DD, 32'h0000_0033);
		ex(f(6'h14, 5'h09, 5'h00, 3'h0, cbt_pkg::MODE_PREDEC));
		ckr(9, 8'h33);
		ckr(26, 8'hff);
		sr(28, 8'h00);
		sr(29, 8'h02);
		w(A_IM, 32'h0000_0005);
		ex(f(6'h18, 5'h00, 5'h02, 3'h1, 2'h0));
		w(A_DA, 32'h0000_0205);
		ck(A_DD, 32'h0000_0033);
		ex(f(6'h15, 5'h0c, 5'h00, 3'h1, 2'h0));
		ckr(12, 8'h33);
		ckr(28, 8'h00);
		$display("end of pointer tests");
		w(cbt_pkg::OFS_PC, 32'h0000_0000);
		w(A_IM, 32'h0000_0123);
		w(A_DA, 32'h0000_0123);
		w(A_DD, 32'h0000_009c);
		ex(f(6'h16, 5'h0d, 5'h00, 3'h0, 2'h0));
		ckr(13, 8'h9c);
		ex(f(6'h19, 5'h00, 5'h02, 3'h0, 2'h0));
		ck(A_DD, 32'h0000_0033);
		ck(cbt_pkg::OFS_PC, 32'h0000_0004);
		w(cbt_pkg::OFS_IO_ADDR, 32'h0000_0005);
		w(A_ID, 32'h0000_00f0);
		w(A_IM, 32'h0000_0005);
		ex(f(6'h04, 5'h00, 5'h00, 3'h0, 2'h0));
		ck(A_ID, 32'h0000_00f1);
		ex(f(6'h05, 5'h00, 5'h00, 3'h7, 2'h0));
		ck(A_ID, 32'h0000_0071);
		ex(f(6'h1e, 5'h00, 5'h02, 3'h0, 2'h0));
		ck(A_ID, 32'h0000_0033);
		w(A_ID, 32'h0000_00a7);
		ex(f(6'h1d, 5'h0e, 5'h00, 3'h0, 2'h0));
		ckr(14, 8'ha7);
		$display("end of direct and io tests");
		sr(0, 8'h34);
		sr(1, 8'h12);
		sr(30, 8'h02);
		sr(31, 8'h00);
		ex(f(6'h1b, 5'h00, 5'h00, 3'h2, 2'h0));
		sr(0, 8'h00);
		ex(f(6'h1a, 5'h00, 5'h00, 3'h2, 2'h0));
		ckr(0, 8'h34);
		sr(30, 8'h03);
		ex(f(6'h1a, 5'h0f, 5'h00, 3'h2, 2'h1));
		ckr(15, 8'h12);
		ckr(30, 8'h04);
		w(cbt_pkg::OFS_SP, 32'h0000_0300);
		ex(f(6'h1c, 5'h00, 5'h02, 3'h0, 2'h0));
		w(A_DA, 32'h0000_0300);
		ck(A_DD, 32'h0000_0033);
		ck(cbt_pkg::OFS_SP, 32'h0000_02ff);
		$display("end of memory tests");
		w(A_FL, 32'h0000_0040);
		w(A_OP, f(6'h1b, 5'h00, 5'h00, 3'h2, 2'h0));
		stall <= 1'b1;
		wr(A_FL, 32'h0000_0000, rs);
		chk({30'h0, rs}, {30'h0, cbt_pkg::RESP_SLVERR});
		stall <= 1'b0;
		idle();
		ck(A_FL, 32'h0000_0040);
		$display("end of refusal test");
		final_report();
	end
endmodule : cpu_bit_and_transfer_ops_tb
